// *** stop_sleep_clock_control.sv ***
`timescale 1ns/10ps
`default_nettype none
// Function
// - writing stop bit halts cpu and peripheral clocks
// - oscillator stops on its final edge
// - reset or pin/source interrupts end halt
// - clocked peripherals never wake; comparator, rtc may
// - wake needs enable and mask bit
// - pins low-active, peripheral flags high-active
// - wake restarts oscillator, cpu clock follows
// - cpu vectors to waking interrupt handler
// - hardware clears stop bit on wake
// - all clocks off except rtc while halted
// - stop plus sleep bits enter deep sleep
// - deep sleep swaps main for backup regulator
// - deep sleep wakes likewise, regulator back on
// - clock select register chooses system clock
// - oscillator enabled except while halted
// - oscillator trim defaults to factory value
// - wake forces clock select to oscillator
// - selection applied without checking the source
// - field codes: osc, slow osc, rtc, pll
// - regulator wait 16 to 128 slow cycles
// - wake mask bits reset to ones
module stop_sleep_clock_control
    import sscc_pkg::*;
#(
    parameter int TRIM_W = 8,
    parameter logic [TRIM_W-1:0] TRIM_DEFAULT = 8'h80
) (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic [1:0] AVS_RESPONSE,
    input wire logic [1:0] EXT_IRQ_PIN_N,
    input wire logic [6:0] PERIPH_IRQ,
    input wire logic SLOW_OSC_TICK,
    output logic OSC_ENABLE,
    output logic [TRIM_W-1:0] OSC_TRIM,
    output logic CPU_CLK_EN,
    output logic PERIPH_CLK_EN,
    output logic RTC_CLK_EN,
    output logic [1:0] CLOCK_SOURCE_FIELD,
    output logic MAIN_REG_EN,
    output logic BACKUP_REG_EN,
    output logic REG_READY,
    output logic WAKE_VECTOR_REQ
);
    sscc_state_type state_q;
    sscc_clock_source_select_type clock_source_select_q;
    sscc_bus_req_type req;
    logic [7:0] wake_source_mask_q;
    logic [7:0] irqen_q;
    logic stop_q;
    logic sleep_q;
    logic deep_q;
    logic [TRIM_W-1:0] trim_q;
    logic [SSCC_WAIT_W-1:0] wait_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [1:0] resp_q;
    logic wake_req;
    logic halt_req;
    logic acc;
    logic wr_go;
    logic hit;

    assign req = '{rd: AVS_READ, wr: AVS_WRITE, addr: AVS_ADDRESS, wdata: AVS_WRITEDATA};
    assign acc = (req.rd | req.wr) & ~ack_q;
    // write lands at the edge where waitrequest is seen low
    assign wr_go = req.wr & ack_q & AVS_BYTEENABLE[0];
    assign hit = (req.addr == SSCC_CLOCK_SOURCE_SELECT_OFS) | (req.addr == SSCC_WAKE_SOURCE_MASK_OFS)
        | (req.addr == SSCC_PWRCTL_OFS) | (req.addr == SSCC_STATUS_OFS)
        | (req.addr == SSCC_IRQEN_OFS);

    // masked, clockless wake qualification
    sscc_wake_detect u_wake (
        .ext_irq_pin_n(EXT_IRQ_PIN_N),
        .periph_irq(PERIPH_IRQ),
        .wake_source_mask(wake_source_mask_q),
        .irq_enable(irqen_q),
        .wake_req(wake_req)
    );

    assign halt_req = (state_q == SSCC_ST_RUN) & stop_q;

    sscc_osc_gate u_osc (
        .clk(CORE_CLK),
        .reset(RESET),
        .halt_req(halt_req),
        .wake_req(wake_req),
        .osc_enable(OSC_ENABLE)
    );

    // mode sequencer
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            state_q <= SSCC_ST_RUN;
        end else begin
            unique case (state_q)
                SSCC_ST_RUN: begin
                    if (stop_q) begin
                        state_q <= SSCC_ST_HALT;
                    end
                end
                SSCC_ST_HALT: begin
                    if (wake_req) begin
                        state_q <= SSCC_ST_WAKE;
                    end
                end
                SSCC_ST_WAKE: begin
                    state_q <= SSCC_ST_RUN;
                end
            endcase
        end
    end

    // deep sleep marker
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            deep_q <= 1'b0;
        end else if (halt_req) begin
            deep_q <= sleep_q;
        end else if (state_q == SSCC_ST_WAKE) begin
            deep_q <= 1'b0;
        end
    end

    // regulator wait counter on slow ticks
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            wait_q <= SSCC_WAIT_W'(SSCC_REG_WAIT_BASE << SSCC_CLOCK_SOURCE_SELECT_RST[3:2]);
        end else if (state_q == SSCC_ST_WAKE && deep_q) begin
            wait_q <= sscc_wait_cycles(clock_source_select_q.regulator_wait_sel);
        end else if (state_q == SSCC_ST_RUN && SLOW_OSC_TICK && wait_q != '0) begin
            wait_q <= wait_q - 1'b1;
        end
    end

    // power control bits
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            stop_q <= 1'b0;
            sleep_q <= 1'b0;
        end else if (state_q == SSCC_ST_WAKE) begin
            stop_q <= 1'b0;
            sleep_q <= 1'b0;
        end else if (wr_go && req.addr == SSCC_PWRCTL_OFS && state_q == SSCC_ST_RUN) begin
            stop_q <= req.wdata[SSCC_PWR_STOP_BIT];
            sleep_q <= req.wdata[SSCC_PWR_SLEEP_BIT];
        end
    end

    // clock select, wake mask, enables, trim
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            clock_source_select_q <= SSCC_CLOCK_SOURCE_SELECT_RST;
            wake_source_mask_q <= SSCC_WAKE_SOURCE_MASK_RST;
            irqen_q <= SSCC_IRQEN_RST;
            trim_q <= TRIM_DEFAULT;
        end else if (state_q == SSCC_ST_WAKE) begin
            clock_source_select_q.clock_source_field <= SSCC_CLK_INTERNAL_OSCILLATOR;
        end else if (wr_go) begin
            unique case (req.addr)
                SSCC_CLOCK_SOURCE_SELECT_OFS: begin
                    clock_source_select_q <= req.wdata[7:0];
                end
                SSCC_WAKE_SOURCE_MASK_OFS: begin
                    wake_source_mask_q <= req.wdata[7:0];
                end
                SSCC_IRQEN_OFS: begin
                    irqen_q <= req.wdata[7:0];
                end
                SSCC_STATUS_OFS: begin
                    trim_q <= req.wdata[8 +: TRIM_W];
                end
                default: begin
                end
            endcase
        end
    end

    // avalon slave: one wait cycle, then answer
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
            resp_q <= 2'h0;
        end else begin
            ack_q <= acc;
            if (acc) begin
                resp_q <= hit ? 2'h0 : 2'h3;
                unique case (req.addr)
                    SSCC_CLOCK_SOURCE_SELECT_OFS: rdata_q <= {24'h0, clock_source_select_q};
                    SSCC_WAKE_SOURCE_MASK_OFS: rdata_q <= {24'h0, wake_source_mask_q};
                    SSCC_IRQEN_OFS: rdata_q <= {24'h0, irqen_q};
                    SSCC_PWRCTL_OFS: rdata_q <= {29'h0, sleep_q, stop_q, 1'b0};
                    SSCC_STATUS_OFS: rdata_q <= {8'h0, 8'(wait_q), 8'(trim_q),
                        4'h0, REG_READY, deep_q, 2'(state_q)};
                    default: rdata_q <= '0;
                endcase
            end
        end
    end

    // wake vector pulse
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            WAKE_VECTOR_REQ <= 1'b0;
        end else begin
            WAKE_VECTOR_REQ <= (state_q == SSCC_ST_WAKE);
        end
    end

    assign AVS_WAITREQUEST = (req.rd | req.wr) & ~ack_q;
    assign AVS_READDATA = rdata_q;
    assign AVS_RESPONSE = resp_q;
    assign CPU_CLK_EN = (state_q != SSCC_ST_HALT) & ~halt_req;
    assign PERIPH_CLK_EN = (state_q != SSCC_ST_HALT) & ~halt_req;
    assign RTC_CLK_EN = 1'b1;
    assign CLOCK_SOURCE_FIELD = clock_source_select_q.clock_source_field;
    assign MAIN_REG_EN = ~((state_q == SSCC_ST_HALT) & deep_q);
    assign BACKUP_REG_EN = (state_q == SSCC_ST_HALT) & deep_q;
    assign REG_READY = (wait_q == '0);
    assign OSC_TRIM = trim_q;
endmodule // stop_sleep_clock_control
`default_nettype wire

// *** sscc_pkg.sv ***
package sscc_pkg;
    // avalon word addresses (byte address / 4 of a 32-bit word bus)
    localparam logic [7:0] SSCC_CLOCK_SOURCE_SELECT_OFS = 8'h8f;
    localparam logic [7:0] SSCC_WAKE_SOURCE_MASK_OFS = 8'h9f;
    localparam logic [7:0] SSCC_PWRCTL_OFS = 8'h87;
    localparam logic [7:0] SSCC_STATUS_OFS = 8'h88;
    localparam logic [7:0] SSCC_IRQEN_OFS = 8'h89;
    // field positions
    localparam int SSCC_PWR_STOP_BIT = 1;
    localparam int SSCC_PWR_SLEEP_BIT = 2;
    // reset values and clock source field codes
    localparam logic [7:0] SSCC_CLOCK_SOURCE_SELECT_RST = 8'h9c;
    localparam logic [7:0] SSCC_WAKE_SOURCE_MASK_RST = 8'hff;
    localparam logic [7:0] SSCC_IRQEN_RST = 8'h00;
    localparam logic [1:0] SSCC_CLK_INTERNAL_OSCILLATOR = 2'h0;
    localparam logic [1:0] SSCC_CLK_SLOW_INTERNAL_OSC_SOURCE = 2'h1;
    localparam logic [1:0] SSCC_CLK_RTC = 2'h2;
    localparam logic [1:0] SSCC_CLK_PLL = 2'h3;
    // regulator wait base, in slow oscillator cycles
    localparam int SSCC_REG_WAIT_BASE = 16;
    localparam int SSCC_WAIT_W = 8;

    typedef enum logic [1:0] {
        SSCC_ST_RUN,
        SSCC_ST_HALT,
        SSCC_ST_WAKE
    } sscc_state_type;

    typedef struct packed {
        logic [3:0] osc_div;
        logic [1:0] regulator_wait_sel;
        logic [1:0] clock_source_field;
    } sscc_clock_source_select_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } sscc_bus_req_type;

    function automatic logic [SSCC_WAIT_W-1:0] sscc_wait_cycles(input logic [1:0] sel);
        sscc_wait_cycles = SSCC_WAIT_W'(SSCC_REG_WAIT_BASE << sel);
    endfunction
endpackage

// *** sscc_wake_detect.sv ***
`timescale 1ns/10ps
`default_nettype none
module sscc_wake_detect
    import sscc_pkg::*;
(
    input wire logic [1:0] ext_irq_pin_n,
    input wire logic [6:0] periph_irq,
    input wire logic [7:0] wake_source_mask,
    input wire logic [7:0] irq_enable,
    output logic wake_req
);
    logic [7:0] level;
    // bits 7..0: sources 8,7,6,4,3,2 high-active, pins 1,0 low-active
    assign level = {periph_irq[6], periph_irq[5], periph_irq[4], periph_irq[2],
                    periph_irq[1], periph_irq[0], ~ext_irq_pin_n[1], ~ext_irq_pin_n[0]};
    // clockless combination of levels
    assign wake_req = |(level & wake_source_mask & irq_enable);
endmodule // sscc_wake_detect
`default_nettype wire

// *** sscc_osc_gate.sv ***
`timescale 1ns/10ps
`default_nettype none
module sscc_osc_gate
    import sscc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic halt_req,
    input wire logic wake_req,
    output logic osc_enable
);
    logic stop_q;
    // drop enable on the last edge, restart on wake
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stop_q <= 1'b0;
        end else if (wake_req) begin
            stop_q <= 1'b0;
        end else if (halt_req) begin
            stop_q <= 1'b1;
        end
    end
    assign osc_enable = ~stop_q | wake_req;
endmodule // sscc_osc_gate
`default_nettype wire

// *** sscc_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module sscc_asserts (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST,
    input wire logic OSC_ENABLE,
    input wire logic CPU_CLK_EN,
    input wire logic PERIPH_CLK_EN,
    input wire logic RTC_CLK_EN,
    input wire logic [1:0] CLOCK_SOURCE_FIELD,
    input wire logic MAIN_REG_EN,
    input wire logic BACKUP_REG_EN,
    input wire logic WAKE_VECTOR_REQ
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    a_bus_ack_next: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("no ack next cycle");
    a_halt_dark: assert property (!CPU_CLK_EN |-> !PERIPH_CLK_EN && RTC_CLK_EN)
        else $error("clocks wrong in halt");
    a_osc_in_run: assert property (CPU_CLK_EN |-> OSC_ENABLE)
        else $error("osc off while running");
    a_osc_stops: assert property ($fell(CPU_CLK_EN) |-> ##[0:2] (!OSC_ENABLE || CPU_CLK_EN))
        else $error("osc not stopped");
    a_wake_resume: assert property ($rose(OSC_ENABLE) |-> ##[1:3] CPU_CLK_EN)
        else $error("cpu clock late");
    a_vec_pulse: assert property (WAKE_VECTOR_REQ |=> !WAKE_VECTOR_REQ)
        else $error("vector not a pulse");
    a_vec_internal_oscillator: assert property (WAKE_VECTOR_REQ |-> CLOCK_SOURCE_FIELD == 2'h0)
        else $error("source not forced");
    a_deep_backup: assert property (BACKUP_REG_EN |-> !MAIN_REG_EN && !CPU_CLK_EN)
        else $error("regulators wrong");
    a_main_back: assert property ($rose(CPU_CLK_EN) |-> ##[0:2] MAIN_REG_EN)
        else $error("main regulator off");
    cover property ($rose(WAKE_VECTOR_REQ));
    cover property ($rose(BACKUP_REG_EN));
    cover property ($fell(CPU_CLK_EN));
endmodule // sscc_asserts
bind stop_sleep_clock_control sscc_asserts u_asserts (.CORE_CLK(CORE_CLK), .RESET(RESET), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .OSC_ENABLE(OSC_ENABLE), .CPU_CLK_EN(CPU_CLK_EN),
    .PERIPH_CLK_EN(PERIPH_CLK_EN), .RTC_CLK_EN(RTC_CLK_EN), .CLOCK_SOURCE_FIELD(CLOCK_SOURCE_FIELD),
    .MAIN_REG_EN(MAIN_REG_EN), .BACKUP_REG_EN(BACKUP_REG_EN), .WAKE_VECTOR_REQ(WAKE_VECTOR_REQ));
`default_nettype wire

// *** sscc_wake_src.sv ***
`timescale 1ns/10ps
`default_nettype none
module sscc_wake_src (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] fire,
    input wire logic ack,
    output logic [1:0] pin_n,
    output logic [6:0] irq
);
    logic [7:0] pend_q;
    // request level held until serviced
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pend_q <= 8'h00;
        end else if (ack) begin
            pend_q <= 8'h00;
        end else begin
            pend_q <= pend_q | fire;
        end
    end
    assign pin_n = ~pend_q[1:0];
    assign irq = {pend_q[7:5], 1'b0, pend_q[4:2]};
endmodule // sscc_wake_src
`default_nettype wire

// *** stop_sleep_clock_control_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module stop_sleep_clock_control_test
    import sscc_pkg::*;
;
    logic clk, rst, rd, wr, wq, osc, cpu, per, rtc, mreg, breg, rdy, vec;
    logic tick = 1'b0;
    logic [7:0] adr, fire, trim;
    logic [31:0] wd, rdat, q;
    logic [1:0] resp, rs, pin_n, fld;
    logic [6:0] pirq;
    int miscompares, tests_run, i, n;
    stop_sleep_clock_control dut (.CORE_CLK(clk), .RESET(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq), .AVS_RESPONSE(resp),
        .EXT_IRQ_PIN_N(pin_n), .PERIPH_IRQ(pirq), .SLOW_OSC_TICK(tick), .OSC_ENABLE(osc), .OSC_TRIM(trim),
        .CPU_CLK_EN(cpu), .PERIPH_CLK_EN(per), .RTC_CLK_EN(rtc), .CLOCK_SOURCE_FIELD(fld), .MAIN_REG_EN(mreg),
        .BACKUP_REG_EN(breg), .REG_READY(rdy), .WAKE_VECTOR_REQ(vec));
    sscc_wake_src src (.clk(clk), .reset(rst), .fire(fire), .ack(vec), .pin_n(pin_n), .irq(pirq));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) tick <= ~tick;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic acc(input logic r, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        rd <= r;
        wr <= !r;
        adr <= a;
        wd <= d;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (wq === 1'b0) break;
        end
        if (k == 50) begin
            miscompares++;
            results;
        end
        q = rdat;
        rs = resp;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic halt_wake(input logic [31:0] mode, input logic [7:0] bits);
        int k;
        acc(0, SSCC_PWRCTL_OFS, mode);
        repeat (3) @(posedge clk);
        chk(cpu, 0, "cpu clk in halt");
        chk({per, rtc, osc}, 3'b010, "clks in halt");
        chk({breg, mreg}, mode[2] ? 2'b10 : 2'b01, "regulators in halt");
        fire <= bits;
        @(posedge clk);
        fire <= 8'h00;
        if (bits == 8'h00) return;
        for (k = 0; k < 100 && vec !== 1'b1; k++) @(posedge clk);
        chk(k < 100, 1, "wake");
        chk(fld, 0, "forced source");
    endtask
    initial begin
        rst = 1'b1;
        {rd, wr, adr, wd, fire, miscompares, tests_run} = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        acc(1, SSCC_CLOCK_SOURCE_SELECT_OFS, 0);
        chk(q, 32'h9c, "clock_source_select reset");
        acc(1, SSCC_WAKE_SOURCE_MASK_OFS, 0);
        chk(q, 32'hff, "wake_source_mask reset");
        acc(1, 8'h10, 0);
        chk(rs, 2'h3, "unmapped response");
        chk(q, 0, "unmapped data");
        for (i = 0; i < 4; i++) begin
            acc(0, SSCC_CLOCK_SOURCE_SELECT_OFS, 32'h94 | i);
            @(posedge clk);
            chk(fld, i, "field");
        end
        acc(0, SSCC_STATUS_OFS, 32'h00005a00);
        @(posedge clk);
        chk(trim, 8'h5a, "trim");
        $display("test registers done");
        acc(0, SSCC_IRQEN_OFS, 32'hff);
        for (i = 0; i < 8; i++) begin
            acc(0, SSCC_CLOCK_SOURCE_SELECT_OFS, 32'h97);
            halt_wake(32'h2, 8'h01 << i);
            acc(1, SSCC_PWRCTL_OFS, 0);
            chk(q[1], 0, "stop bit");
        end
        $display("test wake sources done");
        acc(0, SSCC_WAKE_SOURCE_MASK_OFS, 32'hfe);
        halt_wake(32'h2, 8'h00);
        @(posedge clk);
        fire <= 8'h01;
        repeat (20) @(posedge clk);
        fire <= 8'h00;
        chk(cpu, 0, "masked wake");
        acc(0, SSCC_WAKE_SOURCE_MASK_OFS, 32'hff);
        for (i = 0; i < 100 && cpu !== 1'b1; i++) @(posedge clk);
        chk(cpu, 1, "unmasked wake");
        $display("test mask done");
        halt_wake(32'h6, 8'h02);
        chk(breg, 0, "backup off");
        n = 0;
        for (i = 0; i < 400 && rdy !== 1'b1; i++) begin
            @(posedge clk);
            if (tick) n++;
        end
        chk(mreg, 1, "main reg");
        chk(n >= 29 && n <= 33, 1, "reg wait");
        $display("test deep sleep done");
        results;
    end
endmodule // stop_sleep_clock_control_test
`default_nettype wire
